// >>> rtl/synth_params.svh
// Purpose: Constants of the serial programming port of the dual synthesizer.
// Assumes: A 24-bit word, four latches, registers on one aligned word each.
// Notes:   Field positions of the control words are kept here in one place.
`ifndef SYNTH_PARAMS_SVH
`define SYNTH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------------
`define WORD_W       24
`define SEL_W        2
`define LATCH_N      4
`define LATCH_MAP    8'he4
`define OUT_A_BIT    17
`define OUT_B_BIT    18
`define OSC_BIT      21
`define MON_SEL_HI   20
`define MON_SEL_LO   18
`define MON_POL_BIT  17
`define PWR_OFF_BIT  16
`define MON_SRC_W    6

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define STATUS_OFS   8'h00
`define LATCH_OFS    8'h04
`define CTRL_OFS     8'h14
`define LOADS_OFS    8'h18
`define SHIFT_OFS    8'h1c
`define CTRL_RST     1'b1

`endif

// >>> rtl/synth_pkg.sv
// Purpose: Types shared by the serial programming port.
// Assumes: Constants come from synth_params.svh.
// Notes:   Enumerations only.
package synth_pkg;

   typedef enum logic [1:0] {
      LATCH_IF_REF,
      LATCH_IF_DIV,
      LATCH_RF_REF,
      LATCH_RF_DIV
   } latch_id_t;

   typedef enum logic [2:0] {
      MON_LOW,
      MON_RF_LOCK,
      MON_IF_LOCK,
      MON_RF_N,
      MON_RF_R,
      MON_IF_N,
      MON_IF_R,
      MON_ANALOG
   } mon_sel_t;

endpackage

// >>> rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the hclk domain.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);

   logic [W-1:0] meta_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         level  <= '0;
      end else begin
         meta_q <= pin;
         level  <= meta_q;
      end
   end

endmodule

// >>> rtl/serial_shifter.sv
// Purpose: Three-wire serial front end: shift register and load strobe edge.
// Assumes: Inputs are already synchronised to hclk.
// Notes:   Serial clock period must exceed several hclk periods.
`timescale 1ns/1ps
`include "synth_params.svh"
module serial_shifter (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               sclk_s,
   input  wire logic               sdata_s,
   input  wire logic               load_s,
   output logic [`WORD_W-1:0]      shift_q,
   output logic [`WORD_W-1:0]      word_q,
   output logic                    load_pulse_q
);

   logic sclk_prev_q;
   logic load_prev_q;
   logic sclk_rise;
   logic load_rise;

   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign load_rise = load_s & ~load_prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_prev_q <= 1'b0;
         load_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         load_prev_q <= load_s;
      end
   end

   // The first bit sent ends up in the top bit, so the word arrives MSB first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_q <= '0;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[`WORD_W-2:0], sdata_s};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         word_q       <= '0;
         load_pulse_q <= 1'b0;
      end else begin
         load_pulse_q <= load_rise;
         if (load_rise) begin
            word_q <= shift_q;
         end
      end
   end

   shift_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sclk_rise |=> shift_q == {$past(shift_q[`WORD_W-2:0]), $past(sdata_s)})
      else $error("shift register did not take one bit on a serial clock edge");

   load_snap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      load_rise |=> load_pulse_q && word_q == $past(shift_q))
      else $error("load strobe edge did not capture the shift register");

endmodule

// >>> rtl/synth_serial_program_port.sv
// Purpose: Serial programming port, latches and enable control of the
//          dual RF/IF synthesizer, with an AHB-Lite register view.
// Assumes: Serial pins and enables are asynchronous to hclk and pass two
//          flops; the serial clock is much slower than hclk.
// Notes:   All outputs come from flops; the bus always answers OKAY with
//          no wait states.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "synth_params.svh"
module synth_serial_program_port
   import synth_pkg::*;
#(
   parameter logic [2*`LATCH_N-1:0] LATCH_MAP = `LATCH_MAP
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic                  serial_clock,
   input  wire logic                  serial_data,
   input  wire logic                  load_strobe,
   input  wire logic                  rf_section_enable,
   input  wire logic                  if_section_enable,
   input  wire logic [`MON_SRC_W-1:0] monitor_sources,
   output logic                       general_output_a,
   output logic                       general_output_b,
   output logic                       rf_powered,
   output logic                       if_powered,
   output logic                       rf_pump_drive,
   output logic                       if_pump_drive,
   output logic                       rf_ref_feed,
   output logic                       monitor_lock_output,
   output logic                       monitor_lock_oe
);

   // -------------------------------------------------------------------------
   // Pin synchronisation and serial front end
   // -------------------------------------------------------------------------
   localparam int PIN_W = 5 + `MON_SRC_W;

   logic [PIN_W-1:0]      pins_s;
   logic                  sclk_s;
   logic                  sdata_s;
   logic                  load_s;
   logic                  rf_section_enable_s;
   logic                  if_en_s;
   logic [`MON_SRC_W-1:0] mon_s;
   logic [`WORD_W-1:0]    shift_word;
   logic [`WORD_W-1:0]    load_word;
   logic                  load_pulse;

   pin_sync #(
      .W (PIN_W)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     ({monitor_sources, if_section_enable, rf_section_enable,
                 load_strobe, serial_data, serial_clock}),
      .level   (pins_s)
   );

   assign sclk_s  = pins_s[0];
   assign sdata_s = pins_s[1];
   assign load_s  = pins_s[2];
   assign rf_section_enable_s = pins_s[3];
   assign if_en_s = pins_s[4];
   assign mon_s   = pins_s[PIN_W-1:5];

   serial_shifter u_shifter (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .sclk_s       (sclk_s),
      .sdata_s      (sdata_s),
      .load_s       (load_s),
      .shift_q      (shift_word),
      .word_q       (load_word),
      .load_pulse_q (load_pulse)
   );

   // -------------------------------------------------------------------------
   // Latch selection and the four latches
   // -------------------------------------------------------------------------
   // The control bits are the last two shifted in, so they sit at the bottom.
   function automatic latch_id_t latch_of(input logic [`SEL_W-1:0] ctl);
      latch_of = latch_id_t'(LATCH_MAP[ctl*`SEL_W +: `SEL_W]);
   endfunction

   logic [`WORD_W-1:0] latch_q [`LATCH_N];
   logic               ctrl_q;
   logic [15:0]        loads_q;
   latch_id_t          pick;
   logic               load_take;

   assign pick      = latch_of(load_word[`SEL_W-1:0]);
   assign load_take = load_pulse & ctrl_q;

   for (genvar i = 0; i < `LATCH_N; i++) begin : g_latch
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            latch_q[i] <= '0;
         end else if (load_take && pick == latch_id_t'(i)) begin
            latch_q[i] <= load_word;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loads_q <= '0;
      end else if (load_take) begin
         loads_q <= loads_q + 16'h0001;
      end
   end

   logic [`WORD_W-1:0] if_ref_word;
   logic [`WORD_W-1:0] if_div_word;
   logic [`WORD_W-1:0] rf_ref_word;
   mon_sel_t           mon_sel;
   logic               mon_pol;

   assign if_ref_word = latch_q[LATCH_IF_REF];
   assign if_div_word = latch_q[LATCH_IF_DIV];
   assign rf_ref_word = latch_q[LATCH_RF_REF];
   assign mon_sel     = mon_sel_t'(if_ref_word[`MON_SEL_HI:`MON_SEL_LO]);
   assign mon_pol     = if_ref_word[`MON_POL_BIT];

   // -------------------------------------------------------------------------
   // Section power and charge pump drive
   // -------------------------------------------------------------------------
   // A pump that is not driven stands in high impedance in the analog part.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rf_powered    <= 1'b0;
         rf_pump_drive <= 1'b0;
      end else begin
         rf_powered    <= rf_section_enable_s & ~rf_ref_word[`PWR_OFF_BIT];
         rf_pump_drive <= rf_section_enable_s & ~rf_ref_word[`PWR_OFF_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         if_powered    <= 1'b0;
         if_pump_drive <= 1'b0;
      end else begin
         if_powered    <= if_en_s & ~if_ref_word[`PWR_OFF_BIT];
         if_pump_drive <= if_en_s & ~if_ref_word[`PWR_OFF_BIT];
      end
   end

   // -------------------------------------------------------------------------
   // General outputs and reference routing
   // -------------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         general_output_a <= 1'b0;
         general_output_b <= 1'b0;
         rf_ref_feed      <= 1'b0;
      end else begin
         general_output_a <= if_div_word[`OUT_A_BIT];
         general_output_b <= if_div_word[`OUT_B_BIT];
         rf_ref_feed      <= if_ref_word[`OSC_BIT];
      end
   end

   // -------------------------------------------------------------------------
   // Monitor output
   // -------------------------------------------------------------------------
   // Sources: 0 RF lock, 1 IF lock, 2 RF N, 3 RF R, 4 IF N, 5 IF R.
   logic mon_level;
   logic both_locked;

   assign both_locked = mon_s[0] & mon_s[1];

   always_comb begin
      unique case (mon_sel)
         MON_LOW:     mon_level = 1'b0;
         MON_RF_LOCK: mon_level = mon_s[0];
         MON_IF_LOCK: mon_level = mon_s[1];
         MON_RF_N:    mon_level = mon_s[2];
         MON_RF_R:    mon_level = mon_s[3];
         MON_IF_N:    mon_level = mon_s[4];
         MON_IF_R:    mon_level = mon_s[5];
         MON_ANALOG:  mon_level = 1'b0;
      endcase
   end

   // Analog mode is open drain: pull low while unlocked, release when locked,
   // so an outside filter can average the pulses.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         monitor_lock_output <= 1'b0;
         monitor_lock_oe     <= 1'b0;
      end else if (mon_sel == MON_ANALOG) begin
         monitor_lock_output <= 1'b0;
         monitor_lock_oe     <= ~both_locked;
      end else begin
         monitor_lock_output <= mon_level ^ mon_pol;
         monitor_lock_oe     <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------------------
   logic        addr_phase;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] rd_d;

   assign addr_phase = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         wr_pend_q <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
         wr_addr_q <= haddr[7:0];
      end
   end

   // Clearing this bit ignores the load strobe, so a board can freeze the
   // latches while the serial lines are shared with another part.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `CTRL_RST;
      end else if (wr_pend_q && wr_addr_q == `CTRL_OFS) begin
         ctrl_q <= hwdata[0];
      end
   end

   always_comb begin
      rd_d = 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
         unique case (haddr[7:0])
            `STATUS_OFS: rd_d = {21'h000000, mon_s, if_powered, rf_powered,
                                 monitor_lock_output, if_en_s, rf_section_enable_s};
            `LATCH_OFS:         rd_d = {8'h00, latch_q[0]};
            `LATCH_OFS + 8'h04: rd_d = {8'h00, latch_q[1]};
            `LATCH_OFS + 8'h08: rd_d = {8'h00, latch_q[2]};
            `LATCH_OFS + 8'h0c: rd_d = {8'h00, latch_q[3]};
            `CTRL_OFS:          rd_d = {31'h00000000, ctrl_q};
            `LOADS_OFS:         rd_d = {16'h0000, loads_q};
            `SHIFT_OFS:         rd_d = {8'h00, shift_word};
            default:            rd_d = 32'h00000000;
         endcase
      end
   end

   // Read data is taken at the end of the address phase and stands for the
   // whole data phase, which keeps hrdata straight from a flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_phase && !hwrite) begin
         hrdata <= rd_d;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence load_seen;
      load_take;
   endsequence

   sequence rf_off_seen;
      !rf_section_enable_s;
   endsequence

   sequence if_off_seen;
      !if_en_s;
   endsequence

   latch_pick_a: assert property (load_seen |=> latch_q[$past(pick)] == $past(load_word))
      else $error("selected latch did not take the loaded word");

   latch_map_a: assert property (
      load_seen |-> pick == latch_id_t'(LATCH_MAP[load_word[1:0]*2 +: 2]))
      else $error("latch choice does not follow the control bits");

   rf_down_a: assert property (rf_off_seen |=> !rf_powered && !rf_pump_drive)
      else $error("RF section not powered down with its enable low");

   rf_up_a: assert property (
      rf_section_enable_s && !rf_ref_word[`PWR_OFF_BIT] |=> rf_powered && rf_pump_drive)
      else $error("RF section not powered up as its control word allows");

   if_down_a: assert property (if_off_seen |=> !if_powered && !if_pump_drive)
      else $error("IF section not powered down with its enable low");

   if_up_a: assert property (
      if_en_s |=> if_powered == !$past(if_ref_word[`PWR_OFF_BIT]))
      else $error("IF section power does not follow its control word");

   out_b_a: assert property (##1 general_output_b == $past(if_div_word[`OUT_B_BIT]))
      else $error("second general output does not follow its latch bit");

   out_a_a: assert property (##1 general_output_a == $past(if_div_word[`OUT_A_BIT]))
      else $error("first general output does not follow its latch bit");

   osc_route_a: assert property ($changed(if_ref_word[`OSC_BIT]) |=>
      rf_ref_feed == $past(if_ref_word[`OSC_BIT]))
      else $error("reference routing does not follow its control bit");

   mon_push_a: assert property (mon_sel != MON_ANALOG |=> monitor_lock_oe)
      else $error("monitor output not driven in push-pull mode");

   mon_drain_a: assert property (
      mon_sel == MON_ANALOG |=> !monitor_lock_output && monitor_lock_oe == !$past(both_locked))
      else $error("monitor output not open drain in analog lock mode");

   bus_okay_a: assert property (addr_phase |=> hreadyout && !hresp)
      else $error("bus answer was not a zero-wait OKAY");

   // A frozen port must ignore a strobe entirely, or a shared serial bus
   // could overwrite a latch that belongs to this part.
   load_freeze_a: assert property (load_pulse && !ctrl_q |=>
      latch_q[$past(pick)] == $past(latch_q[pick]))
      else $error("latch changed while loading was switched off");

   read_hold_a: assert property (addr_phase && hwrite |=> $stable(hrdata))
      else $error("read data moved during a write transfer");

endmodule

// >>> sim/serial_host_model.sv
// Purpose: Host controller model that programs words over the three-wire link.
// Assumes: A link clock period of 160 ns, unrelated in phase to hclk.
// Notes:   The clock idles low between frames and the data line idles at the
//          inverse of its last bit, so a stale level is never mistaken for data.
`timescale 1ns/1ps
module serial_host_model (
   output logic serial_clock,
   output logic serial_data,
   output logic load_strobe
);
   initial begin
      serial_clock = 1'b0;
      serial_data  = 1'b1;
      load_strobe  = 1'b0;
   end

   // -------------------------------------------------------------------------
   // Frame transmission
   // -------------------------------------------------------------------------
   // The odd offset keeps every link edge clear of the hclk edges.
   task automatic send_word(input logic [23:0] w);
      #1.3;
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         #40;
         serial_clock = 1'b1;
         #80;
         serial_clock = 1'b0;
         #40;
      end
      load_strobe = 1'b1;
      #80;
      load_strobe = 1'b0;
      serial_data = ~serial_data;
      #40;
   endtask
endmodule

// >>> sim/test_synth_serial_program_port.sv
// Purpose: Self-checking bench of the serial programming port.
// Assumes: Outputs settle within a few hclk after each pin change.
// Notes:   A reversed latch map exercises the mapping parameter.
`timescale 1ns/1ps
`include "synth_params.svh"
module test_synth_serial_program_port;
   import synth_pkg::*;
   localparam logic [7:0] MAP = 8'h1b;
   logic                  hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]           haddr, hwdata, hrdata;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   logic                  serial_clock, serial_data, load_strobe;
   logic                  rf_section_enable, if_section_enable;
   logic [`MON_SRC_W-1:0] monitor_sources;
   logic                  general_output_a, general_output_b, rf_powered, if_powered;
   logic                  rf_pump_drive, if_pump_drive, rf_ref_feed;
   logic                  monitor_lock_output, monitor_lock_oe;
   logic [23:0]           lat [4];
   logic [23:0]           last_shift;
   logic                  ld_en;
   int                    n_loads, n_fail, samples_checked, seed;

   assign hready = hreadyout;

   synth_serial_program_port #(.LATCH_MAP(MAP)) synth_serial_program_port_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .serial_clock(serial_clock), .serial_data(serial_data),
      .load_strobe(load_strobe), .rf_section_enable(rf_section_enable),
      .if_section_enable(if_section_enable), .monitor_sources(monitor_sources),
      .general_output_a(general_output_a), .general_output_b(general_output_b),
      .rf_powered(rf_powered), .if_powered(if_powered),
      .rf_pump_drive(rf_pump_drive), .if_pump_drive(if_pump_drive),
      .rf_ref_feed(rf_ref_feed), .monitor_lock_output(monitor_lock_output),
      .monitor_lock_oe(monitor_lock_oe));

   serial_host_model host_model_inst (
      .serial_clock(serial_clock), .serial_data(serial_data),
      .load_strobe(load_strobe));

   // -------------------------------------------------------------------------
   // Clock, comparisons and verdict
   // -------------------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_b(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #250000;
      n_fail++;
      conclude();
   end

   // -------------------------------------------------------------------------
   // Bus and link tasks
   // -------------------------------------------------------------------------
   // Entered just after a rising edge; only the watchdog ends a wait on hready.
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      rd = hrdata;
      chk_b("hresp", 1'b0, hresp);
   endtask

   task automatic send(input logic [23:0] w);
      logic [1:0] id;
      id = MAP[2*int'(w[1:0]) +: 2];
      host_model_inst.send_word(w);
      if (ld_en) begin
         lat[id] = w;
         n_loads++;
      end
      last_shift = w;
      repeat (10) @(posedge hclk);
   endtask

   task automatic check_all;
      logic [31:0] rd;
      logic [2:0]  sel;
      logic        v, rp, ip;
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, 32'h4 + 4 * i, 32'h0, rd);
         chk_w("latch", {8'h00, lat[i]}, rd);
      end
      ahb(1'b0, 32'h18, 32'h0, rd);
      chk_w("loads", n_loads, rd);
      ahb(1'b0, 32'h1c, 32'h0, rd);
      chk_w("shift", {8'h00, last_shift}, rd);
      rp = rf_section_enable & ~lat[LATCH_RF_REF][16];
      ip = if_section_enable & ~lat[LATCH_IF_REF][16];
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk_w("status", {monitor_sources, ip, rp, if_section_enable, rf_section_enable},
            {rd[10:3], rd[1:0]});
      chk_b("out_a", lat[LATCH_IF_DIV][17], general_output_a);
      chk_b("out_b", lat[LATCH_IF_DIV][18], general_output_b);
      chk_b("rf_pwr", rp, rf_powered);
      chk_b("rf_pump", rp, rf_pump_drive);
      chk_b("if_pwr", ip, if_powered);
      chk_b("if_pump", ip, if_pump_drive);
      chk_b("feed", lat[LATCH_IF_REF][21], rf_ref_feed);
      sel = lat[LATCH_IF_REF][20:18];
      if (sel == 3'd7) begin
         chk_b("mon_oe", ~(monitor_sources[0] & monitor_sources[1]), monitor_lock_oe);
         chk_b("mon", 1'b0, monitor_lock_output);
      end else begin
         v = (sel == 3'd0) ? 1'b0 : monitor_sources[sel - 3'd1];
         chk_b("mon_oe", 1'b1, monitor_lock_oe);
         chk_b("mon", v ^ lat[LATCH_IF_REF][17], monitor_lock_output);
      end
   endtask

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      logic [31:0] rd, w;
      seed = 536;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      rf_section_enable = 1'b0;
      if_section_enable = 1'b0;
      monitor_sources = 6'h00;
      for (int i = 0; i < 4; i++) lat[i] = 24'h0;
      last_shift = 24'h0;
      ld_en = 1'b1;
      n_loads = 0;
      n_fail = 0;
      samples_checked = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      check_all();
      ahb(1'b0, 32'h14, 32'h0, rd);
      chk_w("ctrl", 32'h1, rd);
      ahb(1'b1, 32'h104, 32'hffffffff, rd);
      ahb(1'b0, 32'h104, 32'h0, rd);
      chk_w("unmapped", 32'h0, rd);
      ahb(1'b1, 32'h4, 32'hffffffff, rd);
      check_all();
      // Every control code once, with random payloads.
      for (int c = 0; c < 4; c++) begin
         w = $random(seed);
         w[1:0] = c[1:0];
         send(w[23:0]);
         check_all();
      end
      // Enable pins against the power-off bits of both control words.
      for (int e = 0; e < 8; e++) begin
         rf_section_enable <= e[0];
         if_section_enable <= e[1];
         monitor_sources <= $random(seed);
         w = $random(seed);
         w[16] = e[2];
         w[1:0] = 2'd1;
         send(w[23:0]);
         w = $random(seed);
         w[16] = ~e[2];
         w[1:0] = 2'd3;
         send(w[23:0]);
         check_all();
      end
      // Every monitor selection, random polarity and sources.
      for (int s = 0; s < 8; s++) begin
         monitor_sources <= $random(seed);
         w = $random(seed);
         w[20:18] = s[2:0];
         w[1:0] = 2'd3;
         send(w[23:0]);
         check_all();
      end
      // A load while loading is disabled leaves every latch alone.
      ahb(1'b1, 32'h14, 32'h0, rd);
      ahb(1'b0, 32'h14, 32'h0, rd);
      chk_w("ctrl", 32'h0, rd);
      ld_en = 1'b0;
      w = $random(seed);
      w[1:0] = 2'd2;
      send(w[23:0]);
      check_all();
      ahb(1'b1, 32'h14, 32'h1, rd);
      ld_en = 1'b1;
      w = $random(seed);
      w[1:0] = 2'd2;
      send(w[23:0]);
      check_all();
      conclude();
   end
endmodule
